// >>> src/scl_pkg.sv
// shared constants and types for the chain link control register bank
package scl_pkg;
   localparam logic [3:0]  ADDR_HOST  = 4'h1;
   localparam logic [3:0]  ADDR_LINK  = 4'h2;
   localparam logic [3:0]  ADDR_TXTHR = 4'h3;
   localparam logic [3:0]  ADDR_RXTHR = 4'h4;
   localparam logic [3:0]  ADDR_DEV   = 4'h5;
   localparam logic [15:0] RST_HOST   = 16'h00a0;
   localparam logic [15:0] RST_LINK   = 16'h0000;
   localparam logic [15:0] RST_TXTHR  = 16'h01ff;
   localparam logic [15:0] RST_RXTHR  = 16'h00ff;
   localparam logic [15:0] RST_DEV    = 16'h0000;
   localparam int WDT_LO   = 12;
   localparam int WDT_HI   = 13;
   localparam int CRC_BIT  = 2;
   localparam int SDO_BIT  = 1;
   localparam int ACK_BIT  = 0;
   localparam int SS_LO    = 8;
   localparam int SS_HI    = 9;
   localparam int RATE_LO  = 0;
   localparam int RATE_HI  = 3;
   localparam int FLUSH_BIT = 15;
   localparam int TXTHR_HI = 8;
   localparam int RXTHR_HI = 7;
   localparam int FORCE_BIT = 2;
   localparam int EXIT_BIT  = 0;
   localparam logic [1:0]  WDT_OFF   = 2'h3;
   localparam logic [15:0] CRC_INIT_FALSE  = 16'hffff;
   localparam logic [15:0] CRC_INIT_XMODEM = 16'h0000;
   localparam int CLK_HZ   = 25000000;
   localparam int WDT_T0_MS = 40;
   localparam int WDT_T1_MS = 20;
   localparam int WDT_T2_MS = 10;
   localparam int WDT_C0 = WDT_T0_MS * (CLK_HZ / 1000);
   localparam int WDT_C1 = WDT_T1_MS * (CLK_HZ / 1000);
   localparam int WDT_C2 = WDT_T2_MS * (CLK_HZ / 1000);
   localparam int WORD_W   = 16;
   localparam int FIFO_D   = 8;
   localparam logic [3:0]  BIT_LAST = 4'hf;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] data;
   } scl_regwr_s;
   typedef enum logic [1:0] {
      LNK_IDLE  = 2'b01,
      LNK_SHIFT = 2'b10
   } scl_link_e;
endpackage : scl_pkg

// >>> src/scl_link_control.sv
// chain link control registers, host watchdog, fifos and link serializer
`timescale 1ns/1ps
module scl_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   flush,
   input  wire logic                   inValid,
   input  wire logic [W-1:0]           inData,
   output logic                        inReady,
   output logic                        outValid,
   output logic [W-1:0]                outData,
   input  wire logic                   outReady,
   output logic [$clog2(D+1)-1:0]      count
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   wire           doPush = inValid && inReady;
   wire           doPop  = outValid && outReady;
   assign inReady  = count != ($clog2(D+1))'(D);
   assign outValid = count != '0;
   assign outData  = mem[rdPtr];
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr] <= inData;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= (wrPtr == AW'(D - 1)) ? '0 : wrPtr + AW'(1);
         end
         if (doPop) begin
            rdPtr <= (rdPtr == AW'(D - 1)) ? '0 : rdPtr + AW'(1);
         end
         count <= count + CW'(doPush) - CW'(doPop);
      end
   end
endmodule : scl_fifo

module scl_link_control #(
   parameter int WDT_CYC0 = scl_pkg::WDT_C0,
   parameter int WDT_CYC1 = scl_pkg::WDT_C1,
   parameter int WDT_CYC2 = scl_pkg::WDT_C2,
   parameter int DEPTH    = scl_pkg::FIFO_D
) (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               regWrEn,
   input  wire scl_pkg::scl_regwr_s regWr,
   input  wire logic               regRdEn,
   input  wire logic [3:0]         regRdAddr,
   output logic [15:0]             regRdData,
   input  wire logic               csN,
   input  wire logic               sdoData,
   output logic                    sdoOut,
   output logic                    sdoOeN,
   output logic                    hostCrcVariantSel,
   output logic [15:0]             crcInit,
   output logic                    statusAutoReplyEn,
   output logic [1:0]              linkClockSpreadSel,
   output logic [3:0]              linkBitRateSel,
   output logic                    safeState,
   output logic                    regWriteError,
   input  wire logic               statusClear,
   input  wire logic               txWordValid,
   input  wire logic [15:0]        txWord,
   output logic                    txReady,
   input  wire logic               linkClk,
   output logic                    linkDataOut,
   output logic                    linkTxBusy,
   input  wire logic               rxBusy,
   input  wire logic               rxWordValid,
   input  wire logic [15:0]        rxWord,
   output logic                    rxReady,
   input  wire logic               rxPop,
   output logic [15:0]             rxData,
   output logic                    rxDataValid,
   output logic                    dataReadyN
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [15:0]  hostPortControl;
   logic [15:0]  linkControl;
   logic [15:0]  txFifoThreshold;
   logic [15:0]  rxFifoThreshold;
   logic [15:0]  deviceControl;
   logic [2:0]   csSync;
   logic [2:0]   lclkSync;
   logic [31:0]  wdtCnt;
   logic [CW-1:0] txCount;
   logic [CW-1:0] rxCount;
   logic [15:0]  shiftReg;
   logic [3:0]   bitCnt;
   logic         txGo;
   scl_pkg::scl_link_e linkState;
   scl_pkg::scl_link_e next_linkState;

   // decode of the register port
   wire wrHost  = regWrEn && regWr.addr == scl_pkg::ADDR_HOST;
   wire wrLink  = regWrEn && regWr.addr == scl_pkg::ADDR_LINK;
   wire wrTxThr = regWrEn && regWr.addr == scl_pkg::ADDR_TXTHR;
   wire wrRxThr = regWrEn && regWr.addr == scl_pkg::ADDR_RXTHR;
   wire wrDev   = regWrEn && regWr.addr == scl_pkg::ADDR_DEV;
   wire linkBusy   = linkTxBusy || rxBusy;
   wire linkReject = wrLink && linkBusy;
   wire txFlush = wrTxThr && regWr.data[scl_pkg::FLUSH_BIT];
   wire rxFlush = wrRxThr && regWr.data[scl_pkg::FLUSH_BIT];
   wire forceSafe = wrDev && regWr.data[scl_pkg::FORCE_BIT];
   wire exitSafe  = wrDev && regWr.data[scl_pkg::EXIT_BIT];
   // flush bits are actions only, so they are never stored
   wire [15:0] flushMask = 16'h7fff;
   wire [15:0] devMask   = 16'hfffa;

   // watchdog limit from the two-bit select
   wire [1:0] wdtSel = hostPortControl[scl_pkg::WDT_HI:scl_pkg::WDT_LO];
   wire [31:0] wdtLimit = (wdtSel == 2'h0) ? 32'(WDT_CYC0) :
                          (wdtSel == 2'h1) ? 32'(WDT_CYC1) : 32'(WDT_CYC2);
   // any chip select edge counts as host activity
   wire csActivity = csSync[2] != csSync[1];
   wire wdtFire = wdtSel != scl_pkg::WDT_OFF && wdtCnt >= wdtLimit - 32'd1;
   wire csLow = !csSync[1];
   wire lclkRise = lclkSync[1] && !lclkSync[2];

   wire [9:0] txThr = {1'b0, txFifoThreshold[scl_pkg::TXTHR_HI:0]};
   wire [8:0] rxThr = {1'b0, rxFifoThreshold[scl_pkg::RXTHR_HI:0]};
   wire txAbove = 10'(txCount) > txThr;
   // level 0 stands for one word, so data ready drops only from two words on
   wire rxAbove = 9'(rxCount) > rxThr + 9'h001;
   wire txOutValid;
   wire [15:0] txOutData;
   wire txPop = linkState == scl_pkg::LNK_IDLE && txGo && txOutValid;

   wire [15:0] rdMux =
      (regRdAddr == scl_pkg::ADDR_HOST)  ? hostPortControl :
      (regRdAddr == scl_pkg::ADDR_LINK)  ? linkControl :
      (regRdAddr == scl_pkg::ADDR_TXTHR) ? txFifoThreshold :
      (regRdAddr == scl_pkg::ADDR_RXTHR) ? rxFifoThreshold :
      (regRdAddr == scl_pkg::ADDR_DEV)   ? deviceControl : 16'h0000;

   scl_fifo #(.W(scl_pkg::WORD_W), .D(DEPTH)) txFifo (
      .clk      (mclk),
      .rst      (rst),
      .flush    (txFlush),
      .inValid  (txWordValid),
      .inData   (txWord),
      .inReady  (txReady),
      .outValid (txOutValid),
      .outData  (txOutData),
      .outReady (txPop),
      .count    (txCount)
   );

   scl_fifo #(.W(scl_pkg::WORD_W), .D(DEPTH)) rxFifo (
      .clk      (mclk),
      .rst      (rst),
      .flush    (rxFlush),
      .inValid  (rxWordValid),
      .inData   (rxWord),
      .inReady  (rxReady),
      .outValid (rxDataValid),
      .outData  (rxData),
      .outReady (rxPop),
      .count    (rxCount)
   );

   // registers; reserved bits store what is written
   always_ff @(posedge mclk) begin
      if (rst) begin
         hostPortControl <= scl_pkg::RST_HOST;
         linkControl     <= scl_pkg::RST_LINK;
         txFifoThreshold <= scl_pkg::RST_TXTHR;
         rxFifoThreshold <= scl_pkg::RST_RXTHR;
         deviceControl   <= scl_pkg::RST_DEV;
      end else begin
         if (wrHost) hostPortControl <= regWr.data;
         if (wrLink && !linkBusy) linkControl <= regWr.data;
         if (wrTxThr) txFifoThreshold <= regWr.data & flushMask;
         if (wrRxThr) rxFifoThreshold <= regWr.data & flushMask;
         if (wrDev) deviceControl <= regWr.data & devMask;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (regRdEn) begin
         regRdData <= rdMux;
      end
   end

   // pins cross into mclk through two flops
   always_ff @(posedge mclk) begin
      if (rst) begin
         csSync   <= 3'h7;
         lclkSync <= 3'h0;
      end else begin
         csSync   <= {csSync[1:0], csN};
         lclkSync <= {lclkSync[1:0], linkClk};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || csActivity || wdtFire) begin
         wdtCnt <= 32'h0000_0000;
      end else if (wdtSel != scl_pkg::WDT_OFF) begin
         wdtCnt <= wdtCnt + 32'h0000_0001;
      end
   end

   // force and expiry win over exit in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         safeState <= 1'b0;
      end else if (wdtFire || forceSafe) begin
         safeState <= 1'b1;
      end else if (exitSafe) begin
         safeState <= 1'b0;
      end
   end

   // a rejected write in the clearing cycle still leaves the flag set
   always_ff @(posedge mclk) begin
      if (rst) begin
         regWriteError <= 1'b0;
      end else if (linkReject) begin
         regWriteError <= 1'b1;
      end else if (statusClear) begin
         regWriteError <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sdoOut             <= 1'b1;
         sdoOeN             <= 1'b1;
         hostCrcVariantSel  <= 1'b0;
         crcInit            <= scl_pkg::CRC_INIT_FALSE;
         statusAutoReplyEn  <= 1'b1;
         linkClockSpreadSel <= 2'h0;
         linkBitRateSel     <= 4'h0;
         dataReadyN         <= 1'b1;
      end else begin
         sdoOut <= sdoData;
         sdoOeN <= !(csLow && !hostPortControl[scl_pkg::SDO_BIT]);
         hostCrcVariantSel <= hostPortControl[scl_pkg::CRC_BIT];
         crcInit <= hostPortControl[scl_pkg::CRC_BIT] ?
                    scl_pkg::CRC_INIT_XMODEM : scl_pkg::CRC_INIT_FALSE;
         statusAutoReplyEn <= !hostPortControl[scl_pkg::ACK_BIT];
         linkClockSpreadSel <= linkControl[scl_pkg::SS_HI:scl_pkg::SS_LO];
         linkBitRateSel <= linkControl[scl_pkg::RATE_HI:scl_pkg::RATE_LO];
         dataReadyN <= !rxAbove;
      end
   end

   // once started, the burst drains the fifo empty before waiting again
   always_ff @(posedge mclk) begin
      if (rst || txFlush) begin
         txGo <= 1'b0;
      end else if (txAbove) begin
         txGo <= 1'b1;
      end else if (!txOutValid) begin
         txGo <= 1'b0;
      end
   end

   always_comb begin
      next_linkState = linkState;
      unique case (linkState)
         scl_pkg::LNK_IDLE: begin
            if (txPop) next_linkState = scl_pkg::LNK_SHIFT;
         end
         scl_pkg::LNK_SHIFT: begin
            if (lclkRise && bitCnt == scl_pkg::BIT_LAST) begin
               next_linkState = scl_pkg::LNK_IDLE;
            end
         end
         default: next_linkState = scl_pkg::LNK_IDLE;
      endcase
   end

   // msb first, one bit per link clock rising edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         linkState   <= scl_pkg::LNK_IDLE;
         shiftReg    <= 16'h0000;
         bitCnt      <= 4'h0;
         linkDataOut <= 1'b0;
         linkTxBusy  <= 1'b0;
      end else begin
         linkState  <= next_linkState;
         linkTxBusy <= next_linkState == scl_pkg::LNK_SHIFT;
         if (txPop) begin
            shiftReg <= txOutData;
            bitCnt   <= 4'h0;
         end else if (linkState == scl_pkg::LNK_SHIFT && lclkRise) begin
            linkDataOut <= shiftReg[15];
            shiftReg    <= {shiftReg[14:0], 1'b0};
            bitCnt      <= bitCnt + 4'h1;
         end
      end
   end

   AST_WDT_OFF: assert property (@(posedge mclk) disable iff (rst)
      (wdtSel == scl_pkg::WDT_OFF && !forceSafe) |=> !$rose(safeState))
      else $error("safe state entered with watchdog disabled");
   AST_WDT_SAFE: assert property (@(posedge mclk) disable iff (rst)
      wdtFire |=> safeState)
      else $error("watchdog expiry did not enter safe state");
   AST_CRC_SEL: assert property (@(posedge mclk) disable iff (rst)
      ##1 crcInit == ($past(hostPortControl[scl_pkg::CRC_BIT]) ?
                      scl_pkg::CRC_INIT_XMODEM : scl_pkg::CRC_INIT_FALSE))
      else $error("crc init does not follow selector");
   AST_SDO_HIZ: assert property (@(posedge mclk) disable iff (rst)
      hostPortControl[scl_pkg::SDO_BIT] |=> sdoOeN)
      else $error("output driven while disabled");
   AST_SDO_DRV: assert property (@(posedge mclk) disable iff (rst)
      (!hostPortControl[scl_pkg::SDO_BIT] && csLow) |=> !sdoOeN)
      else $error("output not driven while selected");
   AST_ACK: assert property (@(posedge mclk) disable iff (rst)
      hostPortControl[scl_pkg::ACK_BIT] |=> !statusAutoReplyEn)
      else $error("auto-reply not suppressed");
   AST_TX_FLUSH: assert property (@(posedge mclk) disable iff (rst)
      txFlush |=> txCount == '0 && txFifoThreshold[scl_pkg::FLUSH_BIT] == 1'b0)
      else $error("tx fifo not flushed");
   AST_TX_START: assert property (@(posedge mclk) disable iff (rst)
      (txAbove && linkState == scl_pkg::LNK_IDLE && !txFlush) |=> ##1 linkTxBusy)
      else $error("tx did not start at threshold");
   AST_RX_FLUSH: assert property (@(posedge mclk) disable iff (rst)
      rxFlush |=> rxCount == '0)
      else $error("rx fifo not flushed");
   AST_DATA_READY_PIN: assert property (@(posedge mclk) disable iff (rst)
      rxAbove |=> !dataReadyN)
      else $error("data ready not low above threshold");
   AST_REJECT: assert property (@(posedge mclk) disable iff (rst)
      linkReject |=> regWriteError && $stable(linkControl))
      else $error("busy link_control write not refused");
endmodule : scl_link_control

// >>> tb/scl_link_peer.sv
// far end of the chain link: clocks out words while the link is busy
`timescale 1ns/1ps
module scl_link_peer (
   input  wire logic        linkTxBusy,
   input  wire logic        linkDataOut,
   output logic             linkClk,
   output logic [15:0]      gotWord,
   output int               nWords
);
   initial begin
      linkClk = 1'b0;
      gotWord = 16'h0000;
      nWords  = 0;
      forever begin
         wait (linkTxBusy === 1'b1);
         #37;
         // clock stands still between words; the design moves a bit out after each
         // rising edge, so the bit is taken half a period later, before the fall
         for (int i = 15; i >= 0; i--) begin
            #160 linkClk = 1'b1;
            #160 gotWord[i] = linkDataOut;
            linkClk = 1'b0;
         end
         // busy has dropped by now; a burst raises it again for the next word
         nWords++;
      end
   end
endmodule : scl_link_peer

// >>> tb/scl_link_control_tb.sv
// self-checking bench for the chain link control register bank
`timescale 1ns/1ps
module scl_link_control_tb;
   logic mclk = 0, rst = 1, regWrEn = 0, regRdEn = 0, csN = 1, sdoData = 0;
   logic statusClear = 0, txWordValid = 0, rxBusy = 0, rxWordValid = 0, rxPop = 0;
   logic [3:0]  regRdAddr = 4'h0;
   logic [15:0] txWord = 16'h0000, rxWord = 16'h0000, w, q[8];
   scl_pkg::scl_regwr_s regWr = '0;
   logic [15:0] regRdData, crcInit, rxData, gotWord;
   logic sdoOut, sdoOeN, hostCrcVariantSel, statusAutoReplyEn, safeState, regWriteError;
   logic txReady, linkClk, linkDataOut, linkTxBusy, rxReady, rxDataValid, dataReadyN;
   logic [1:0] linkClockSpreadSel;
   logic [3:0] linkBitRateSel;
   int n_errors = 0, num_checks = 0, nWords, n0;
   always #20 mclk = ~mclk;
   scl_link_control #(.WDT_CYC0(40), .WDT_CYC1(20), .WDT_CYC2(10), .DEPTH(8)) u_dut (
      .mclk(mclk), .rst(rst), .regWrEn(regWrEn), .regWr(regWr), .regRdEn(regRdEn),
      .regRdAddr(regRdAddr), .regRdData(regRdData), .csN(csN), .sdoData(sdoData),
      .sdoOut(sdoOut), .sdoOeN(sdoOeN), .hostCrcVariantSel(hostCrcVariantSel),
      .crcInit(crcInit), .statusAutoReplyEn(statusAutoReplyEn),
      .linkClockSpreadSel(linkClockSpreadSel), .linkBitRateSel(linkBitRateSel),
      .safeState(safeState), .regWriteError(regWriteError), .statusClear(statusClear),
      .txWordValid(txWordValid), .txWord(txWord), .txReady(txReady), .linkClk(linkClk),
      .linkDataOut(linkDataOut), .linkTxBusy(linkTxBusy), .rxBusy(rxBusy),
      .rxWordValid(rxWordValid), .rxWord(rxWord), .rxReady(rxReady), .rxPop(rxPop),
      .rxData(rxData), .rxDataValid(rxDataValid), .dataReadyN(dataReadyN));
   scl_link_peer u_peer (.linkTxBusy(linkTxBusy), .linkDataOut(linkDataOut),
      .linkClk(linkClk), .gotWord(gotWord), .nWords(nWords));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWrEn <= 1'b1;
      regWr   <= '{addr: a, data: d};
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      regRdEn   <= 1'b1;
      regRdAddr <= a;
      @(posedge mclk);
      regRdEn <= 1'b0;
      #1 chk("regRdData", regRdData, exp);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   // expected value of crcInit from the selector bit
   function automatic logic [15:0] crc_of(input logic s);
      return s ? scl_pkg::CRC_INIT_XMODEM : scl_pkg::CRC_INIT_FALSE;
   endfunction : crc_of
   // restart the watchdog from a chip select edge, then time one code
   task automatic wdt_case(input logic [1:0] code, input int ncyc);
      wr(4'h1, 16'h3000);
      wr(4'h5, 16'h0001);
      @(posedge mclk);
      csN <= 1'b0;
      cyc(4);
      @(posedge mclk);
      csN <= 1'b1;
      cyc(4);
      wr(4'h1, {2'h0, code, 12'h000});
      cyc(ncyc - 1);
      chk("wdtEarly", safeState, 1'b0);
      cyc(1);
      chk("wdtFire", safeState, 1'b1);
   endtask : wdt_case
   task automatic conclude();
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // whole run is well under a thousand cycles; this bound only catches a hang
   initial begin
      #3000000;
      n_errors++;
      conclude();
   end
   initial begin
      void'($urandom(44));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(4'h1, 16'h00a0);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h01ff);
      rd(4'h4, 16'h00ff);
      rd(4'h5, 16'h0000);
      rd(4'h7, 16'h0000);
      chk("autoReply", statusAutoReplyEn, 1'b1);
      chk("crcInit", crcInit, 16'hffff);
      // watchdog off, then leave any safe state the default timeout raised
      wr(4'h1, 16'h3000);
      wr(4'h5, 16'h0001);
      cyc(60);
      chk("safeOff", safeState, 1'b0);
      for (int i = 0; i < 6; i++) begin
         w = 16'($urandom()) | 16'h3000;
         wr(4'h1, w);
         cyc(1);
         chk("crcSel", hostCrcVariantSel, w[2]);
         chk("crcInit", crcInit, crc_of(w[2]));
         chk("autoReply", statusAutoReplyEn, !w[0]);
         rd(4'h1, w);
         w = 16'($urandom());
         wr(4'h2, w);
         cyc(1);
         chk("spread", linkClockSpreadSel, w[9:8]);
         chk("rate", linkBitRateSel, w[3:0]);
         rd(4'h2, w);
      end
      wr(4'h1, 16'h3000);
      csN     <= 1'b0;
      sdoData <= 1'b1;
      cyc(5);
      chk("oeDrive", sdoOeN, 1'b0);
      chk("sdoOut", sdoOut, 1'b1);
      wr(4'h1, 16'h3002);
      cyc(4);
      chk("oeDisabled", sdoOeN, 1'b1);
      csN     <= 1'b1;
      sdoData <= 1'b0;
      cyc(5);
      chk("oeDeselect", sdoOeN, 1'b1);
      chk("sdoOutLow", sdoOut, 1'b0);
      // each code must fire exactly at its count, not a cycle early
      wdt_case(2'h2, 10);
      wdt_case(2'h1, 20);
      wdt_case(2'h0, 40);
      wr(4'h1, 16'h3000);
      wr(4'h5, 16'h0001);
      cyc(2);
      chk("safeExit", safeState, 1'b0);
      wr(4'h5, 16'h0004);
      cyc(2);
      chk("safeForce", safeState, 1'b1);
      wr(4'h5, 16'h0001);
      cyc(2);
      chk("safeExit", safeState, 1'b0);
      rd(4'h5, 16'h0000);
      // rx: threshold 0 means more than one word pulls data ready low
      wr(4'h4, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         q[i] = 16'($urandom());
         @(posedge mclk);
         rxWordValid <= 1'b1;
         rxWord      <= q[i];
         if (i == 2) begin
            cyc(0);
            chk("drdyOne", dataReadyN, 1'b1);
         end
      end
      @(posedge mclk);
      rxWordValid <= 1'b0;
      cyc(2);
      chk("rxFull", rxReady, 1'b0);
      chk("data_ready_pin", dataReadyN, 1'b0);
      for (int i = 0; i < 8; i++) begin
         chk("rxData", rxData, q[i]);
         @(posedge mclk);
         rxPop <= 1'b1;
         @(posedge mclk);
         rxPop <= 1'b0;
         #1;
      end
      cyc(2);
      chk("drdyEmpty", dataReadyN, 1'b1);
      @(posedge mclk);
      rxWordValid <= 1'b1;
      cyc(3);
      rxWordValid <= 1'b0;
      wr(4'h4, 16'h8000);
      cyc(2);
      chk("rxFlushed", rxDataValid, 1'b0);
      chk("drdyFlush", dataReadyN, 1'b1);
      rd(4'h4, 16'h0000);
      // tx: one word goes out msb first; link_control writes refused meanwhile
      wr(4'h2, 16'h0105);
      wr(4'h3, 16'h0000);
      w = 16'($urandom());
      n0 = nWords;
      @(posedge mclk);
      txWordValid <= 1'b1;
      txWord      <= w;
      @(posedge mclk);
      txWordValid <= 1'b0;
      for (int i = 0; i < 20 && linkTxBusy !== 1'b1; i++) cyc(1);
      chk("txStart", linkTxBusy, 1'b1);
      wr(4'h2, 16'h0003);
      cyc(1);
      chk("wrErr", regWriteError, 1'b1);
      rd(4'h2, 16'h0105);
      for (int i = 0; i < 3000 && nWords == n0; i++) cyc(1);
      chk("txWord", gotWord, w);
      cyc(200);
      @(posedge mclk);
      statusClear <= 1'b1;
      @(posedge mclk);
      statusClear <= 1'b0;
      rxBusy      <= 1'b1;
      cyc(1);
      chk("errClr", regWriteError, 1'b0);
      wr(4'h2, 16'h0003);
      cyc(1);
      chk("wrErrRx", regWriteError, 1'b1);
      rxBusy <= 1'b0;
      rd(4'h2, 16'h0105);
      // threshold above depth: fifo fills and refuses, flush empties it
      wr(4'h3, 16'h01ff);
      @(posedge mclk);
      txWordValid <= 1'b1;
      cyc(9);
      txWordValid <= 1'b0;
      chk("txFull", txReady, 1'b0);
      chk("txIdle", linkTxBusy, 1'b0);
      wr(4'h3, 16'h81ff);
      cyc(2);
      chk("txFlushed", txReady, 1'b1);
      rd(4'h3, 16'h01ff);
      conclude();
   end
endmodule : scl_link_control_tb
